// File: logic/rai_pkg.sv
// package for the right adc input mix configuration registers
package rai_pkg;
    localparam logic [6:0] RAI_FIRST_OFS = 7'h16;
    localparam logic [6:0] RAI_SECOND_OFS = 7'h17;
    localparam logic [7:0] RAI_FIRST_RST = 8'h78;
    localparam logic [7:0] RAI_SECOND_RST = 8'h78;
    localparam int RAI_DIFF_BIT = 7;
    localparam int RAI_LEVEL_LSB = 3;
    localparam int RAI_PWR_BIT = 2;
    localparam int RAI_BIAS_BIT = 2;
    localparam int RAI_SS_LSB = 0;
    localparam logic [3:0] RAI_LEVEL_OFF = 4'hf;
    localparam logic [3:0] RAI_LEVEL_MAX = 4'h8;
    localparam logic [4:0] RAI_HALF_DB_PER_CODE = 5'h3;
    localparam logic [7:0] RAI_SECOND_WMASK = 8'hfc;
    localparam logic [1:0] RAI_SS_ONE_FS = 2'h0;
    localparam logic [1:0] RAI_SS_TWO_FS = 2'h1;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } rai_req_t;

    typedef struct packed {
        logic first_diff;
        logic [4:0] first_atten_half_db;
        logic first_connect;
        logic adc_power_up;
        logic soft_step_en;
        logic soft_step_two_fs;
        logic second_diff;
        logic [4:0] second_atten_half_db;
        logic second_connect;
        logic weak_cm_bias;
    } rai_cfg_t;

    typedef struct packed {
        logic [7:0] first;
        logic [7:0] second;
        logic [7:0] rdata;
        logic rvalid;
        rai_cfg_t cfg;
    } rai_state_t;
endpackage

// File: logic/rai_regs.sv
// right adc input mix configuration registers with decoded analog controls
`timescale 1ns/1ps
module rai_regs (
    input wire logic clk,
    input wire logic rst,
    input rai_pkg::rai_req_t req,
    output logic [7:0] rdata_q,
    output logic rvalid_q,
    output rai_pkg::rai_cfg_t cfg_q
);
    rai_pkg::rai_state_t st_q;
    rai_pkg::rai_state_t st_d;

    // attenuation in half-dB units; codes outside the valid set leave the input off
    function automatic logic [5:0] level_decode(input logic [3:0] code, input logic coarse);
        logic ok;
        logic [4:0] att;
        ok = (code <= rai_pkg::RAI_LEVEL_MAX) && (!coarse || code[1:0] == 2'h0);
        att = ok ? 5'({1'b0, code} * rai_pkg::RAI_HALF_DB_PER_CODE) : 5'h00;
        level_decode = {att, ok};
    endfunction

    always_comb begin
        logic [5:0] lv1;
        logic [5:0] lv2;
        lv1 = 6'h00;
        lv2 = 6'h00;
        st_d = st_q;
        st_d.rvalid = req.rd;
        if (req.wr && req.addr == rai_pkg::RAI_FIRST_OFS) begin
            st_d.first = req.wdata;
        end
        if (req.wr && req.addr == rai_pkg::RAI_SECOND_OFS) begin
            st_d.second = req.wdata & rai_pkg::RAI_SECOND_WMASK;
        end
        if (req.addr == rai_pkg::RAI_FIRST_OFS) begin
            st_d.rdata = st_q.first;
        end else if (req.addr == rai_pkg::RAI_SECOND_OFS) begin
            st_d.rdata = st_q.second;
        end else begin
            st_d.rdata = 8'h00;
        end
        if (!req.rd) begin
            st_d.rdata = st_q.rdata;
        end
        lv1 = level_decode(st_d.first[rai_pkg::RAI_LEVEL_LSB +: 4], 1'b0);
        lv2 = level_decode(st_d.second[rai_pkg::RAI_LEVEL_LSB +: 4], 1'b1);
        st_d.cfg.first_diff = st_d.first[rai_pkg::RAI_DIFF_BIT];
        st_d.cfg.first_atten_half_db = lv1[5:1];
        // disconnect code / auto route on valid code
        st_d.cfg.first_connect = lv1[0];
        st_d.cfg.adc_power_up = st_d.first[rai_pkg::RAI_PWR_BIT];
        st_d.cfg.soft_step_en = !st_d.first[rai_pkg::RAI_SS_LSB + 1];
        st_d.cfg.soft_step_two_fs = st_d.first[rai_pkg::RAI_SS_LSB +: 2] == rai_pkg::RAI_SS_TWO_FS;
        st_d.cfg.second_diff = st_d.second[rai_pkg::RAI_DIFF_BIT];
        st_d.cfg.second_atten_half_db = lv2[5:1];
        st_d.cfg.second_connect = lv2[0];
        st_d.cfg.weak_cm_bias = st_d.second[rai_pkg::RAI_BIAS_BIT];
        // reset defaults; cfg outputs clear to zero and follow the registers again from the first edge after reset
        if (rst) begin
            st_d.first = rai_pkg::RAI_FIRST_RST;
            st_d.second = rai_pkg::RAI_SECOND_RST;
            st_d.rdata = 8'h00;
            st_d.rvalid = 1'b0;
            st_d.cfg = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    assign rdata_q = st_q.rdata;
    assign rvalid_q = st_q.rvalid;
    assign cfg_q = st_q.cfg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic past_rst_q;
    always_ff @(posedge clk) begin
        past_rst_q <= rst;
    end

    AST_RESET_DEFAULT: assert property (past_rst_q |-> st_q.first == 8'h78 && st_q.second == 8'h78)
        else $error("registers not at default after reset");
    AST_FIRST_DIFF: assert property ($past(req.wr) && $past(req.addr) == 7'h16
        && !past_rst_q |-> cfg_q.first_diff == $past(req.wdata[7]))
        else $error("first input mode does not follow write");
    AST_FIRST_ATTEN: assert property (!past_rst_q && st_q.first[6:3] <= 4'h8
        |-> cfg_q.first_atten_half_db == 5'(st_q.first[6:3] * 5'h03) && cfg_q.first_connect)
        else $error("first attenuation wrong");
    AST_FIRST_OFF: assert property (st_q.first[6:3] == 4'hf |-> !cfg_q.first_connect)
        else $error("first input connected on disconnect code");
    AST_AUTO_ROUTE: assert property ($past(req.wr) && $past(req.addr) == 7'h16
        && $past(req.wdata[6:3]) <= 4'h8 && !past_rst_q |-> cfg_q.first_connect)
        else $error("valid gain write did not route input");
    AST_POWER: assert property (!past_rst_q |-> cfg_q.adc_power_up == st_q.first[2])
        else $error("adc power does not follow bit 2");
    AST_SOFT_STEP: assert property (!past_rst_q
        |-> cfg_q.soft_step_en == (st_q.first[1:0] != 2'h2 && st_q.first[1:0] != 2'h3)
        && cfg_q.soft_step_two_fs == (st_q.first[1:0] == 2'h1))
        else $error("soft-step decode wrong");
    AST_SECOND_DIFF: assert property (!past_rst_q |-> cfg_q.second_diff == st_q.second[7])
        else $error("second input mode wrong");
    AST_SECOND_ATTEN: assert property (!past_rst_q && st_q.second[6:3] == 4'h4
        |-> cfg_q.second_atten_half_db == 5'h0c && cfg_q.second_connect)
        else $error("second -6 dB code wrong");
    AST_SECOND_OFF: assert property (st_q.second[6:3] == 4'hf |-> !cfg_q.second_connect)
        else $error("second input connected on disconnect code");
    AST_BIAS: assert property (!past_rst_q |-> cfg_q.weak_cm_bias == st_q.second[2])
        else $error("weak bias does not follow bit 2");
    AST_RO_ZERO: assert property (st_q.second[1:0] == 2'h0)
        else $error("read-only bits not zero");
    AST_READBACK: assert property (req.rd && req.addr == 7'h17 && !req.wr
        ##1 1 |-> rvalid_q && rdata_q == $past(st_q.second))
        else $error("readback of second register wrong");

    // write path: outside reset, stored bytes follow writes and nothing else
    // first register stores the written byte
    AST_FIRST_WRITE: assert property (req.wr && req.addr == rai_pkg::RAI_FIRST_OFS
        |=> st_q.first == $past(req.wdata))
        else $error("first register did not store the write");
    AST_SECOND_WRITE: assert property (req.wr && req.addr == rai_pkg::RAI_SECOND_OFS
        |=> st_q.second[7:2] == $past(req.wdata[7:2]) && st_q.second[1:0] == 2'h0)
        else $error("second register write stored wrongly");
    AST_HOLD_NO_WRITE: assert property (!req.wr
        |=> $stable(st_q.first) && $stable(st_q.second))
        else $error("register changed without a write");
    AST_UNMAPPED_WRITE: assert property (req.wr && req.addr != rai_pkg::RAI_FIRST_OFS
        && req.addr != rai_pkg::RAI_SECOND_OFS
        |=> $stable(st_q.first) && $stable(st_q.second))
        else $error("unmapped write changed a register");
    AST_FIRST_READBACK: assert property (req.rd && req.addr == rai_pkg::RAI_FIRST_OFS
        |=> rvalid_q && rdata_q == $past(st_q.first))
        else $error("readback of first register wrong");
    AST_UNMAPPED_READ: assert property (req.rd && req.addr != rai_pkg::RAI_FIRST_OFS
        && req.addr != rai_pkg::RAI_SECOND_OFS |=> rvalid_q && rdata_q == 8'h00)
        else $error("unmapped read not zero");
    AST_RVALID_PULSE: assert property (!req.rd |=> !rvalid_q)
        else $error("read valid without a read");
    AST_RDATA_HOLD: assert property (!req.rd |=> $stable(rdata_q))
        else $error("read data changed without a read");
    // non-gain codes read as an open input, so a stray write stays silent in the mixer
    // codes above 1000 disconnect
    AST_FIRST_RESERVED: assert property (!past_rst_q && st_q.first[6:3] > 4'h8
        |-> !cfg_q.first_connect && cfg_q.first_atten_half_db == 5'h00)
        else $error("first input routed on a non-gain code");
    AST_SECOND_ZERO_DB: assert property (!past_rst_q && st_q.second[6:3] == 4'h0
        |-> cfg_q.second_connect && cfg_q.second_atten_half_db == 5'h00)
        else $error("second 0 dB code wrong");
    AST_SECOND_MAX: assert property (!past_rst_q && st_q.second[6:3] == 4'h8
        |-> cfg_q.second_connect && cfg_q.second_atten_half_db == 5'h18)
        else $error("second -12 dB code wrong");
    AST_SECOND_RESERVED: assert property (!past_rst_q && st_q.second[6:3] != 4'h0
        && st_q.second[6:3] != 4'h4 && st_q.second[6:3] != 4'h8
        |-> !cfg_q.second_connect && cfg_q.second_atten_half_db == 5'h00)
        else $error("second input routed on a non-gain code");
    // controls follow a write on the next edge
    // power follows write
    AST_POWER_WRITE: assert property (req.wr && req.addr == rai_pkg::RAI_FIRST_OFS
        |=> cfg_q.adc_power_up == $past(req.wdata[2]))
        else $error("adc power did not follow the write");
    AST_SOFT_STEP_WRITE: assert property (req.wr && req.addr == rai_pkg::RAI_FIRST_OFS
        |=> cfg_q.soft_step_en == ($past(req.wdata[1:0]) < 2'h2))
        else $error("soft-step did not follow the write");
    AST_SECOND_DIFF_WRITE: assert property (req.wr && req.addr == rai_pkg::RAI_SECOND_OFS
        |=> cfg_q.second_diff == $past(req.wdata[7]))
        else $error("second input mode did not follow the write");
    AST_BIAS_WRITE: assert property (req.wr && req.addr == rai_pkg::RAI_SECOND_OFS
        |=> cfg_q.weak_cm_bias == $past(req.wdata[2]))
        else $error("weak bias did not follow the write");
    AST_SECOND_ROUTE_WRITE: assert property (req.wr
        && req.addr == rai_pkg::RAI_SECOND_OFS && req.wdata[6:3] == 4'h4
        |=> cfg_q.second_connect && cfg_q.second_atten_half_db == 5'h0c)
        else $error("-6 dB write did not route the second input");
    AST_RESET_OUTPUTS: assert property (past_rst_q
        |-> cfg_q == '0 && !rvalid_q && rdata_q == 8'h00)
        else $error("outputs not cleared by reset");

    COV_FIRST_ROUTE: cover property (!cfg_q.first_connect ##1 cfg_q.first_connect);
    COV_SECOND_ROUTE: cover property (cfg_q.second_connect && cfg_q.second_atten_half_db == 5'h18);
    COV_POWER_UP: cover property (!cfg_q.adc_power_up ##1 cfg_q.adc_power_up);
    COV_READ: cover property (rvalid_q && rdata_q == 8'h78);
    COV_TWO_FS: cover property (cfg_q.soft_step_two_fs);
endmodule

// File: dv/tb.sv
// self-checking bench for the right adc input mix registers
`timescale 1ns/1ps
module tb;
    logic clk;
    logic rst;
    rai_pkg::rai_req_t req;
    logic [7:0] rdata_q;
    logic rvalid_q;
    rai_pkg::rai_cfg_t cfg_q;
    logic [7:0] f_m, s_m, v;
    int miscompares, check_count, seed, i;

    rai_regs u_rai_regs (.clk(clk), .rst(rst), .req(req), .rdata_q(rdata_q),
        .rvalid_q(rvalid_q), .cfg_q(cfg_q));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // expected decode; reserved level codes read as not connected
    function automatic rai_pkg::rai_cfg_t exp_cfg(input logic [7:0] f, input logic [7:0] s);
        rai_pkg::rai_cfg_t c;
        c = '0;
        c.first_diff = f[7];
        c.first_connect = (f[6:3] <= 4'h8);
        c.first_atten_half_db = c.first_connect ? 5'(f[6:3]) * 5'h3 : 5'h0;
        c.adc_power_up = f[2];
        c.soft_step_en = ~f[1];
        c.soft_step_two_fs = (f[1:0] == 2'h1);
        c.second_diff = s[7];
        c.second_connect = (s[6:3] == 4'h0) || (s[6:3] == 4'h4) || (s[6:3] == 4'h8);
        c.second_atten_half_db = c.second_connect ? 5'(s[6:3]) * 5'h3 : 5'h0;
        c.weak_cm_bias = s[2];
        return c;
    endfunction

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(posedge clk);
        #1 req.wr = 1'b0;
        if (a == 7'h16) f_m = d;
        if (a == 7'h17) s_m = d & 8'hfc;
        chk("cfg", 24'(exp_cfg(f_m, s_m)), 24'(cfg_q));
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk);
        #1 req.rd = 1'b1;
        req.addr = a;
        @(posedge clk);
        #1 req.rd = 1'b0;
        chk("rvalid", 24'h1, 24'(rvalid_q));
        chk("rdata", 24'(e), 24'(rdata_q));
        @(posedge clk);
        #1 chk("rvalid_end", 24'h0, 24'(rvalid_q));
        chk("rdata_hold", 24'(e), 24'(rdata_q));
    endtask

    // watchdog so a stuck run still reaches the verdict
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        complete_run();
    end

    initial begin
        seed = 32'h3a3e;
        rst = 1'b1;
        req = '0;
        f_m = 8'h78;
        s_m = 8'h78;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1 chk("cfg_reset", 24'(exp_cfg(f_m, s_m)), 24'(cfg_q));
        rd(7'h16, 8'h78);
        rd(7'h17, 8'h78);
        $display("test reset done");
        // every legal first level code plus disconnect, all soft-step modes
        // legal codes, all four modes
        for (i = 0; i < 10; i++) begin
            v = 8'($random(seed));
            v[6:3] = (i == 9) ? 4'hf : 4'(i);
            v[1:0] = 2'(i);
            wr(7'h16, v);
            rd(7'h16, v);
        end
        $display("test first register done");
        for (i = 0; i < 4; i++) begin
            v = 8'($random(seed)) & 8'hfc;
            v[6:3] = (i == 3) ? 4'hf : 4'(i * 4);
            wr(7'h17, v);
            rd(7'h17, v & 8'hfc);
        end
        $display("test second register done");
        // unmapped places leave the stored state alone and read zero
        wr(7'h15, 8'hff);
        rd(7'h15, 8'h00);
        rd(7'h18, 8'h00);
        rd(7'h16, f_m);
        $display("test unmapped done");
        // a reset in mid-run restores the defaults over written values
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("cfg_in_reset", 24'h0, 24'(cfg_q));
        chk("rdata_in_reset", 24'h0, 24'(rdata_q));
        rst = 1'b0;
        f_m = 8'h78;
        s_m = 8'h78;
        @(posedge clk);
        #1 chk("cfg_after_reset", 24'(exp_cfg(f_m, s_m)), 24'(cfg_q));
        rd(7'h16, 8'h78);
        rd(7'h17, 8'h78);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
